// >>> cdm_cfg.svh
// offsets, field positions, reset values and timing counts for the mode/power-down block
`ifndef CDM_CFG_SVH
`define CDM_CFG_SVH

`define CDM_OFS_CFG        8'h0F
`define CDM_OFS_TIMER      8'h10
`define CDM_OFS_DAC1       8'h11
`define CDM_OFS_DAC2       8'h12

`define CDM_CFG_RST        8'h19
`define CDM_TIMER_RST      8'h40
`define CDM_DAC_RST        8'hC0

`define CDM_BIT_EN_CH1     4
`define CDM_BIT_EN_CH2     3
`define CDM_MODE_MSB       2
`define CDM_MODE_LSB       0
`define CDM_TMO_MSB        5
`define CDM_TMO_LSB        0
`define CDM_BIT_DAC_ON     7
`define CDM_BIT_DAC_AUTO   6
`define CDM_CODE_MSB       5
`define CDM_CODE_LSB       0

`define CDM_MODE_IDLE      3'h0
`define CDM_MODE_CONT      3'h1
`define CDM_MODE_SINGLE    3'h2
`define CDM_MODE_PDOWN     3'h3

`define CDM_CODE_MAX       6'h3F
`define CDM_CODE_MIN       6'h00
`define CDM_TMO_OFF        6'h00

`define CDM_STEP_HOURS     64'h4
`define CDM_SEC_PER_HOUR   64'hE10
`define CDM_NS_PER_SEC     64'h3B9ACA00
`define CDM_CLK_PERIOD_NS  64'hA
`define CDM_STEP_CYCLES    (`CDM_STEP_HOURS * `CDM_SEC_PER_HOUR * `CDM_NS_PER_SEC \
                            / `CDM_CLK_PERIOD_NS)

`endif

// >>> cdm_pkg.sv
// types shared by the mode/power-down control block
package cdm_pkg;
  typedef logic [7:0] cdm_byte_t;
  typedef logic [2:0] cdm_mode_t;
  typedef enum logic {CDM_ST_IDLE, CDM_ST_CONV} cdm_state_t;
endpackage

// >>> cdm_control.sv
// conversion mode, channel enables, auto power-down timer and offset DAC registers
`timescale 1ns/100ps
`include "cdm_cfg.svh"

module cdm_control #(
  parameter int          AVG_W       = 16,
  parameter logic [63:0] STEP_CYCLES = `CDM_STEP_CYCLES
) (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire cdm_pkg::cdm_byte_t reg_wdata_in,
  input  wire logic              reg_rd_in,
  output cdm_pkg::cdm_byte_t     reg_rdata_out,
  input  wire logic              cmp1_active_in,
  input  wire logic              cmp2_active_in,
  input  wire logic              adaptive_mode_in,
  input  wire logic              conv_done_in,
  input  wire logic [AVG_W-1:0]  ch1_avg_in,
  input  wire logic [AVG_W-1:0]  ch2_avg_in,
  output logic                   conv_start_out,
  output logic                   conv_channel_out,
  output logic                   analog_power_on_out,
  output logic                   ch1_dac_on_out,
  output logic [5:0]             ch1_dac_code_out,
  output logic                   ch2_dac_on_out,
  output logic [5:0]             ch2_dac_code_out
);
  import cdm_pkg::*;

  localparam logic [AVG_W-1:0] AVG_HIGH = AVG_W'(3) << (AVG_W - 2);
  localparam logic [AVG_W-1:0] AVG_LOW  = AVG_W'(1) << (AVG_W - 2);

  cdm_byte_t        converter_setup;
  cdm_byte_t        auto_sleep_timer;
  cdm_byte_t        offset_dac [2];
  cdm_state_t       state;
  logic             cur_ch;
  logic [1:0]       pend;
  logic [63:0]      presc;
  logic [5:0]       steps;
  logic [AVG_W-1:0] avg [2];

  cdm_mode_t  mode;
  logic       en1;
  logic       en2;
  logic       any_en;
  logic       wr_cfg;
  logic       wr_tmr;
  logic       done_hit;
  logic       single_end;
  logic       restart;
  logic       step_tick;
  logic       sleep_fire;
  logic [5:0] tmo;
  logic       next_ch;

  assign mode     = converter_setup[`CDM_MODE_MSB:`CDM_MODE_LSB];
  assign en1      = converter_setup[`CDM_BIT_EN_CH1];
  assign en2      = converter_setup[`CDM_BIT_EN_CH2];
  assign any_en   = en1 | en2;
  assign tmo      = auto_sleep_timer[`CDM_TMO_MSB:`CDM_TMO_LSB];
  assign wr_cfg   = reg_wr_in && (reg_addr_in == `CDM_OFS_CFG);
  assign wr_tmr   = reg_wr_in && (reg_addr_in == `CDM_OFS_TIMER);
  assign done_hit = (state == CDM_ST_CONV) && conv_done_in;
  assign avg[0]   = ch1_avg_in;
  assign avg[1]   = ch2_avg_in;

  // continuous mode alternates only while the other channel is enabled
  assign next_ch = cur_ch ? ~en1 : en2;

  // single sequence ends when no other channel is left pending
  assign single_end = done_hit && (mode == `CDM_MODE_SINGLE) &&
                      ((pend & ~(2'b01 << cur_ch)) == 2'b00);

  // setup register; a host write beats the hardware mode rewrite
  // timeout beats single end, else the expiry would be lost for 64 steps
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      converter_setup <= `CDM_CFG_RST;
    end else if (wr_cfg) begin
      converter_setup <= reg_wdata_in;
    end else if (sleep_fire) begin
      converter_setup[`CDM_MODE_MSB:`CDM_MODE_LSB] <= `CDM_MODE_PDOWN;
    end else if (single_end) begin
      converter_setup[`CDM_MODE_MSB:`CDM_MODE_LSB] <= `CDM_MODE_IDLE;
    end
  end

  // bits 7:6 are stored as written; the host keeps them at 01
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      auto_sleep_timer <= `CDM_TIMER_RST;
    end else if (wr_tmr) begin
      auto_sleep_timer <= reg_wdata_in;
    end
  end

  // reserved modes fall through to no conversion at all
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state            <= CDM_ST_IDLE;
      cur_ch           <= 1'b0;
      pend             <= 2'b00;
      conv_start_out   <= 1'b0;
      conv_channel_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      case (state)
        CDM_ST_IDLE: begin
          if (any_en && (mode == `CDM_MODE_CONT || mode == `CDM_MODE_SINGLE)) begin
            state            <= CDM_ST_CONV;
            cur_ch           <= ~en1;
            conv_channel_out <= ~en1;
            conv_start_out   <= 1'b1;
            pend             <= {en2, en1};
          end
        end
        CDM_ST_CONV: begin
          if (mode != `CDM_MODE_CONT && mode != `CDM_MODE_SINGLE) begin
            state <= CDM_ST_IDLE;
          end else if (conv_done_in) begin
            if (mode == `CDM_MODE_CONT && any_en) begin
              cur_ch           <= next_ch;
              conv_channel_out <= next_ch;
              conv_start_out   <= 1'b1;
            end else if (mode == `CDM_MODE_SINGLE && !single_end) begin
              cur_ch           <= ~cur_ch;
              conv_channel_out <= ~cur_ch;
              conv_start_out   <= 1'b1;
              pend             <= pend & ~(2'b01 << cur_ch);
            end else begin
              state <= CDM_ST_IDLE;
              pend  <= 2'b00;
            end
          end
        end
        default: begin
          state <= CDM_ST_IDLE;
        end
      endcase
    end
  end

  // analog side off only in power-down; the register port never sleeps
  assign analog_power_on_out = (mode != `CDM_MODE_PDOWN);

  // timeout: prescaler makes one tick per four-hour step
  assign restart = cmp1_active_in || cmp2_active_in || wr_tmr ||
                   (tmo == `CDM_TMO_OFF) || (mode == `CDM_MODE_PDOWN);
  assign step_tick  = (presc == STEP_CYCLES - 64'h1);
  assign sleep_fire = !restart && step_tick && ((steps + 6'h01) == tmo);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || restart) begin
      presc <= 64'h0;
      steps <= 6'h00;
    end else if (step_tick) begin
      presc <= 64'h0;
      steps <= steps + 6'h01;
    end else begin
      presc <= presc + 64'h1;
    end
  end

  // per-channel offset DAC registers and self adjust
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dac
      logic hit;
      logic adj;
      logic [5:0] code;
      assign hit  = reg_wr_in && (reg_addr_in == (gi == 0 ? `CDM_OFS_DAC1 : `CDM_OFS_DAC2));
      assign code = offset_dac[gi][`CDM_CODE_MSB:`CDM_CODE_LSB];
      assign adj  = done_hit && (cur_ch == 1'(gi)) && adaptive_mode_in &&
                    offset_dac[gi][`CDM_BIT_DAC_AUTO];
      always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
          offset_dac[gi] <= `CDM_DAC_RST;
        end else if (hit) begin
          offset_dac[gi] <= reg_wdata_in;
        end else if (adj && avg[gi] > AVG_HIGH && code != `CDM_CODE_MAX) begin
          offset_dac[gi][`CDM_CODE_MSB:`CDM_CODE_LSB] <= code + 6'h01;
        end else if (adj && avg[gi] < AVG_LOW && code != `CDM_CODE_MIN) begin
          offset_dac[gi][`CDM_CODE_MSB:`CDM_CODE_LSB] <= code - 6'h01;
        end
      end
    end
  endgenerate

  assign ch1_dac_on_out   = offset_dac[0][`CDM_BIT_DAC_ON];
  assign ch1_dac_code_out = offset_dac[0][`CDM_CODE_MSB:`CDM_CODE_LSB];
  assign ch2_dac_on_out   = offset_dac[1][`CDM_BIT_DAC_ON];
  assign ch2_dac_code_out = offset_dac[1][`CDM_CODE_MSB:`CDM_CODE_LSB];

  // read data registered; unmapped offsets read zero
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `CDM_OFS_CFG:   reg_rdata_out <= converter_setup;
        `CDM_OFS_TIMER: reg_rdata_out <= auto_sleep_timer;
        `CDM_OFS_DAC1:  reg_rdata_out <= offset_dac[0];
        `CDM_OFS_DAC2:  reg_rdata_out <= offset_dac[1];
        default:        reg_rdata_out <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_idle_no_start: assert property (
    (state == CDM_ST_IDLE && mode == `CDM_MODE_IDLE) |=> !conv_start_out)
    else $error("conversion started in idle mode");

  a_cont_alternate: assert property (
    (done_hit && mode == `CDM_MODE_CONT && en1 && en2)
    |=> conv_start_out && (conv_channel_out != $past(conv_channel_out)))
    else $error("continuous mode did not alternate channels");

  a_single_second: assert property (
    (done_hit && mode == `CDM_MODE_SINGLE && pend == 2'b11 && !wr_cfg)
    |=> conv_start_out && (conv_channel_out == ~$past(cur_ch)))
    else $error("single mode skipped the second channel");

  a_single_return: assert property (
    (single_end && !wr_cfg && !sleep_fire) |=> (mode == `CDM_MODE_IDLE) && (state == CDM_ST_IDLE))
    else $error("single sequence did not return to idle");

  a_pdown_quiet: assert property (
    (mode == `CDM_MODE_PDOWN && !wr_cfg) |=> !conv_start_out && !analog_power_on_out)
    else $error("activity while powered down");

  a_sleep_entry: assert property (
    (sleep_fire && !wr_cfg) |=> (mode == `CDM_MODE_PDOWN) && !analog_power_on_out)
    else $error("timeout did not enter power-down");

  a_sleep_disabled: assert property (
    (tmo == `CDM_TMO_OFF) |-> !sleep_fire)
    else $error("power-down with timeout disabled");

  a_cmp_restart: assert property (
    (cmp1_active_in || cmp2_active_in) |=> (steps == 6'h00) && (presc == 64'h0))
    else $error("comparator activity did not restart timeout");

  a_reset_values: assert property (
    $fell(sys_rst_in) |-> (auto_sleep_timer == `CDM_TIMER_RST) &&
      (converter_setup == `CDM_CFG_RST) && (offset_dac[0] == `CDM_DAC_RST))
    else $error("wrong register reset value");

  a_timer_read: assert property (
    (reg_rd_in && reg_addr_in == `CDM_OFS_TIMER) |=> reg_rdata_out == $past(auto_sleep_timer))
    else $error("timer readback mismatch");

  a_dac_write: assert property (
    (reg_wr_in && reg_addr_in == `CDM_OFS_DAC2) |=> offset_dac[1] == $past(reg_wdata_in))
    else $error("channel 2 offset register write lost");

  a_dac_step_up: assert property (
    (g_dac[0].adj && !g_dac[0].hit && avg[0] > AVG_HIGH && g_dac[0].code != `CDM_CODE_MAX)
    |=> ch1_dac_code_out == $past(g_dac[0].code) + 6'h01)
    else $error("offset code did not step up");

  c_cont_swap: cover property (done_hit && mode == `CDM_MODE_CONT && en1 && en2);
  c_single_done: cover property (single_end);
  c_sleep: cover property (sleep_fire);
  c_dac_adjust: cover property (g_dac[1].adj && avg[1] < AVG_LOW);

endmodule

// >>> cdm_host.sv
// host model issuing single-byte register reads and writes
`timescale 1ns/100ps
`include "cdm_cfg.svh"

module cdm_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            rd_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `CDM_OFS_CFG) v[`CDM_MODE_MSB] = 1'b0;
    if (a == `CDM_OFS_TIMER) v[7:6] = 2'b01;
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= v;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    // released lines flip so a stale value is never mistaken for a live one
    wdata_out <= ~v;
    addr_out  <= ~a;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the mode and power-down control block
`timescale 1ns/100ps
`include "cdm_cfg.svh"

module testbench;
  import cdm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr;
  logic        wr, rd, start, chan, pwr, d1on, d2on;
  cdm_byte_t   wdata, rdata, rv, v, a, r;
  logic        cmp1 = 1'b0;
  logic        cmp2 = 1'b0;
  logic        adapt = 1'b0;
  logic        done = 1'b0;
  logic [15:0] avg1 = 16'h8000;
  logic [15:0] avg2 = 16'h8000;
  logic [5:0]  d1code, d2code;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cnt;
  logic        chq[$];
  logic [7:0]  sgl[3] = '{8'h1A, 8'h12, 8'h0A};
  logic [15:0] sn[3] = '{16'h2, 16'h1, 16'h1};
  logic        sc[3] = '{1'b0, 1'b0, 1'b1};
  logic [5:0]  c1[3] = '{6'h05, 6'h3F, 6'h10};
  logic [5:0]  c2[3] = '{6'h05, 6'h00, 6'h10};
  logic [15:0] a1[3] = '{16'hFFFF, 16'hFFFF, 16'hC000};
  logic [15:0] a2[3] = '{16'h0000, 16'h0000, 16'h4000};

  always #5 clk = ~clk;

  cdm_control #(.AVG_W(16), .STEP_CYCLES(64'hA)) dut (
    .sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .cmp1_active_in(cmp1),
    .cmp2_active_in(cmp2), .adaptive_mode_in(adapt), .conv_done_in(done),
    .ch1_avg_in(avg1), .ch2_avg_in(avg2), .conv_start_out(start), .conv_channel_out(chan),
    .analog_power_on_out(pwr), .ch1_dac_on_out(d1on), .ch1_dac_code_out(d1code),
    .ch2_dac_on_out(d2on), .ch2_dac_code_out(d2code));

  cdm_host host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .wdata_out(wdata), .rd_out(rd));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [5:0] adj(input logic [5:0] c, input logic [15:0] avg);
    if (avg > 16'hC000 && c != 6'h3F) return c + 6'h01;
    if (avg < 16'h4000 && c != 6'h00) return c - 6'h01;
    return c;
  endfunction

  task automatic run_single(input logic [7:0] s);
    chq.delete();
    host.write_reg(`CDM_OFS_CFG, s);
    for (int i = 0; i < 40; i++) begin
      host.read_reg(`CDM_OFS_CFG, rv);
      if (rv[2:0] === `CDM_MODE_IDLE) break;
    end
    chk(rv, {s[7:3], 3'h0});
  endtask

  // converter stand-in with random latency; records each started channel
  initial begin
    forever begin
      @(posedge clk);
      #1;
      while (start === 1'b1) begin
        chq.push_back(chan);
        repeat ($urandom_range(1, 4)) @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        #1;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'h7a9d));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.read_reg(8'h0F + i[7:0], rv);
      chk(rv, i == 0 ? `CDM_CFG_RST : i == 1 ? `CDM_TIMER_RST : `CDM_DAC_RST);
    end
    chk({d1on, d1code, d2on, d2code}, 16'h2040);
    repeat (60) @(posedge clk);
    chk(16'(chq.size() >= 6), 16'h1);
    for (int i = 0; i < 6; i++) chk(chq[i], i[0]);
    host.write_reg(`CDM_OFS_CFG, 8'h18);
    repeat (2) @(posedge clk);
    chq.delete();
    repeat (50) @(posedge clk);
    chk(16'(chq.size()), 16'h0);
    chk(pwr, 1'b1);
    foreach (sgl[i]) begin
      run_single(sgl[i]);
      chk(16'(chq.size()), sn[i]);
      chk(chq[0], sc[i]);
    end
    adapt <= 1'b1;
    foreach (c1[i]) begin
      host.write_reg(`CDM_OFS_DAC1, {2'b11, c1[i]});
      host.write_reg(`CDM_OFS_DAC2, {2'b11, c2[i]});
      avg1 <= a1[i];
      avg2 <= a2[i];
      run_single(8'h1A);
      chk(d1code, adj(c1[i], a1[i]));
      chk(d2code, adj(c2[i], a2[i]));
    end
    adapt <= 1'b0;
    repeat (30) begin
      a = $urandom_range(0, 1) ? `CDM_OFS_DAC2 : `CDM_OFS_DAC1;
      v = 8'($urandom);
      host.write_reg(a, v);
      host.read_reg(a, rv);
      chk(rv, v);
      chk(a[0] ? {d1on, d1code} : {d2on, d2code}, {v[7], v[5:0]});
      r = 8'($urandom_range(8'h13, 8'hFF));
      host.read_reg(r, rv);
      chk(rv, 8'h00);
    end
    host.write_reg(`CDM_OFS_CFG, 8'h1B);
    #1;
    chk(pwr, 1'b0);
    host.write_reg(`CDM_OFS_DAC1, 8'hC7);
    host.read_reg(`CDM_OFS_DAC1, rv);
    chk(rv, 8'hC7);
    host.write_reg(`CDM_OFS_CFG, 8'h18);
    #1;
    chk(pwr, 1'b1);
    // two steps of ten cycles, counted from the edge that takes the write
    host.write_reg(`CDM_OFS_TIMER, 8'h42);
    cnt = 0;
    while (pwr === 1'b1 && cnt < 40) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(16'(cnt), 16'h14);
    host.read_reg(`CDM_OFS_CFG, rv);
    chk(rv, 8'h1B);
    host.read_reg(`CDM_OFS_TIMER, rv);
    chk(rv, 8'h42);
    host.write_reg(`CDM_OFS_CFG, 8'h18);
    #1;
    chk(pwr, 1'b1);
    host.write_reg(`CDM_OFS_TIMER, 8'h42);
    for (int k = 0; k < 6; k++) begin
      repeat (14) @(posedge clk);
      cmp1 <= ~k[0];
      cmp2 <= k[0];
      @(posedge clk);
      cmp1 <= 1'b0;
      cmp2 <= 1'b0;
    end
    chk(pwr, 1'b1);
    host.write_reg(`CDM_OFS_TIMER, 8'h40);
    repeat (100) @(posedge clk);
    chk(pwr, 1'b1);
    conclude();
  end
endmodule
